// [pkg/psas_consts.vh]
`ifndef PSAS_CONSTS_VH
`define PSAS_CONSTS_VH
// register byte offsets
`define PSAS_CTRL          12'h000
`define PSAS_VFSEL         12'h004
`define PSAS_FMAX          12'h008
`define PSAS_ACC1          12'h00c
`define PSAS_DEC1          12'h010
`define PSAS_ACC2          12'h014
`define PSAS_DEC2          12'h018
`define PSAS_STATUS        12'h01c
`define PSAS_RAMPDUR       12'h020
`define PSAS_TBL_BASE      12'h100
// table word indices
`define PSAS_IX_SPEED      6'd0
`define PSAS_IX_RAMP       6'd8
`define PSAS_IX_SEQF       6'd23
`define PSAS_IX_RTIME      6'd32
`define PSAS_IX_DIR        6'd40
`define PSAS_IX_HOLE       6'd31
`define PSAS_IX_LAST       6'd47
// ctrl fields
`define PSAS_CTRL_PMODE    0
`define PSAS_CTRL_SMODE_LO 1
`define PSAS_CTRL_SMODE_HI 3
// limits, 0.01 Hz and 0.1 s units
`define PSAS_FREQ_MAX      16'd59900
`define PSAS_TIME_MAX      16'd36000
`define PSAS_RAMP_MIN      16'd1
`define PSAS_DIR_MAX       16'd2
`define PSAS_VF_PROG       4'd7
`define PSAS_VF60_FIRST    4'd4
`define PSAS_F50           16'd5000
`define PSAS_F60           16'd6000
// reset values
`define PSAS_RST_ACC       16'd100
`define PSAS_RST_FMAX      16'd6000
// direction codes
`define PSAS_DIR_STOP      2'd0
`define PSAS_DIR_FWD       2'd1
`define PSAS_DIR_REV       2'd2
// timing
`define PSAS_CLK_NS        20
`define PSAS_TICK_NS       100000000
`endif

// [rtl/psas_mem.v]
`timescale 1ns/1ps
// setting table: one write port, two registered read ports
module psas_mem #(
	parameter DW = 16,
	parameter AW = 6
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	input  wire [AW-1:0] ra_addr,
	output reg  [DW-1:0] ra_data,
	input  wire [AW-1:0] rb_addr,
	output reg  [DW-1:0] rb_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	integer i;

	// reset clears every entry so no step or preset starts undefined
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < (1<<AW); i = i + 1)
				mem[i] <= {DW{1'b0}};
			ra_data <= {DW{1'b0}};
			rb_data <= {DW{1'b0}};
		end else begin
			if (we)
				mem[waddr] <= wdata;
			ra_data <= mem[ra_addr];
			rb_data <= mem[rb_addr];
		end
	end
endmodule

// [rtl/psas_div.v]
`timescale 1ns/1ps
// restoring divider, one quotient bit per clock, saturating result
module psas_div #(
	parameter NW = 32,
	parameter DW = 16
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          start,
	input  wire [NW-1:0] num,
	input  wire [DW-1:0] den,
	output reg           busy,
	output reg           done,
	output reg  [DW-1:0] quo
);
	reg [NW-1:0] q_q;
	reg [DW:0]   rem_q;
	reg [DW-1:0] den_q;
	reg [5:0]    cnt_q;
	reg          last_q;
	wire [DW:0]  trial;

	assign trial = {rem_q[DW-1:0], q_q[NW-1]} - {1'b0, den_q};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_q   <= {NW{1'b0}};
			rem_q <= {(DW+1){1'b0}};
			den_q <= {DW{1'b0}};
			cnt_q <= 6'h00;
			last_q <= 1'b0;
			busy  <= 1'b0;
			done  <= 1'b0;
			quo   <= {DW{1'b0}};
		end else begin
			done   <= 1'b0;
			last_q <= 1'b0;
			if (start) begin
				q_q   <= num;
				rem_q <= {(DW+1){1'b0}};
				den_q <= den;
				cnt_q <= NW[5:0];
				busy  <= 1'b1;
			end else if (busy) begin
				if (!trial[DW]) begin
					rem_q <= trial;
					q_q   <= {q_q[NW-2:0], 1'b1};
				end else begin
					rem_q <= {rem_q[DW-1:0], q_q[NW-1]};
					q_q   <= {q_q[NW-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01) begin
					busy   <= 1'b0;
					last_q <= 1'b1;
				end
			end else if (last_q) begin
				// zero divisor or overflow gives the longest duration
				if (den_q == {DW{1'b0}} || q_q[NW-1:DW] != {(NW-DW){1'b0}})
					quo <= {DW{1'b1}};
				else
					quo <= q_q[DW-1:0];
				// done rises with quo on the same edge so the reader never takes the old quotient
				done <= 1'b1;
			end
		end
	end
endmodule

// [rtl/psas_top.v]
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "psas_consts.vh"
// Function
// - preset mode 0 shares global ramps, 1 gives each preset its own pair
// - eight preset speeds 0.00 to 599.00 Hz; preset 0 is keypad frequency
// - sixteen preset ramp times, each 0.1 to 3600.0 s
// - common mode uses selected global pair 1 or 2 for every preset
// - individual mode uses the target preset's own accel or decel time
// - ramp duration equals time times frequency change over maximum frequency
// - maximum is programmable value for pattern 7, else 50 or 60 Hz
// - mode 0 off; 1,4 single; 2,5 periodic; 3,6 hold final step
// - restart: modes 1-3 resume unfinished step, modes 4-6 restart at the lowest step with a nonzero running time
// - steps 1-7 use own frequency command; step 0 uses keypad frequency
// - each step has a running time 0.00 to 3600.0 s
// - each step has direction: 0 stop, 1 forward, 2 reverse
// - while sequencing, ramps use the selected global pair
module psas_top #(
	parameter TICK_CYC = `PSAS_TICK_NS / `PSAS_CLK_NS
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        run_switch,
	input  wire        reverse_sel,
	input  wire [2:0]  speed_sel,
	input  wire        ramp_pair2_sel,
	input  wire        seq_enable,
	output reg  [15:0] freq_cmd,
	output reg         run_cmd,
	output reg         fwd_cmd,
	output reg         rev_cmd,
	output reg  [15:0] ramp_time,
	output reg         ramp_accel,
	output reg  [15:0] ramp_dur,
	output reg         seq_busy,
	output reg  [2:0]  seq_step
);
	localparam S_IDLE = 2'd0;
	localparam S_RUN  = 2'd1;
	localparam S_HOLD = 2'd2;
	localparam S_DONE = 2'd3;

	reg         pmode_q;
	reg  [2:0]  smode_q;
	reg  [3:0]  vf_q;
	reg  [15:0] fmax_q, acc1_q, dec1_q, acc2_q, dec2_q;
	reg  [1:0]  st_q;
	reg  [2:0]  step_q;
	reg  [15:0] elap_q;
	reg  [31:0] tick_q;
	reg         resume_q, go_d1_q;
	reg  [7:0]  nz_q;
	reg  [2:0]  ph_q, ph1_q, rr_q, rr1_q, sel_q;
	reg  [15:0] spd_q, sfrq_q, stime_q, pacc_q, pdec_q;
	reg  [1:0]  sdir_q;
	reg  [5:0]  rb_addr;
	reg  [15:0] tgt, rt_sel, dlt, fmax_eff, wval;
	reg  [1:0]  dir_now;
	reg         run_now;
	reg  [31:0] rd_d;
	reg         map_ok;
	reg  [3:0]  nfirst, nnext;
	wire [15:0] ra_data, rb_data, div_q;
	wire        div_done;
	wire [5:0]  tix = paddr[7:2];
	wire        in_tbl = paddr[11:8] == `PSAS_TBL_BASE >> 8 && tix <= `PSAS_IX_LAST
	                     && tix != `PSAS_IX_HOLE;
	wire        acc_ph = psel & penable;
	wire        wr_go = acc_ph & pwrite & pready;
	wire        seq_go = smode_q != 3'd0 && seq_enable && run_switch;
	wire        seq_on = seq_go && (st_q == S_RUN || st_q == S_HOLD);
	wire        tick = tick_q == TICK_CYC - 1;
	wire        resumable = smode_q <= 3'd3;
	wire [15:0] trun = elap_q + 16'd1;

	// lowest enabled step above s; bit 3 set when none remains
	function [3:0] nxt;
		input [2:0] s;
		input [7:0] m;
		integer k;
		begin
			nxt = 4'h8;
			for (k = 7; k >= 0; k = k - 1)
				if (k > s && m[k])
					nxt = k[3:0];
		end
	endfunction

	psas_mem #(.DW(16), .AW(6)) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr_go & in_tbl),
		.waddr   (tix),
		.wdata   (wval),
		.ra_addr (tix),
		.ra_data (ra_data),
		.rb_addr (rb_addr),
		.rb_data (rb_data)
	);

	// clamp written table values to their ranges
	always @* begin
		wval = pwdata[15:0];
		if (pwdata[31:16] != 16'h0000)
			wval = 16'hffff;
		if (tix < `PSAS_IX_RAMP || (tix > `PSAS_IX_SEQF && tix < `PSAS_IX_RTIME)) begin
			if (wval > `PSAS_FREQ_MAX)
				wval = `PSAS_FREQ_MAX;
		end else if (tix < `PSAS_IX_SEQF + 6'd1) begin
			if (wval > `PSAS_TIME_MAX)
				wval = `PSAS_TIME_MAX;
			else if (wval < `PSAS_RAMP_MIN)
				wval = `PSAS_RAMP_MIN;
		end else if (tix < `PSAS_IX_DIR) begin
			if (wval > `PSAS_TIME_MAX)
				wval = `PSAS_TIME_MAX;
		end else if (wval > `PSAS_DIR_MAX) begin
			wval = `PSAS_DIR_MAX;
		end
	end

	// apb read decode; data comes one cycle into the access phase
	always @* begin
		rd_d   = 32'h0000_0000;
		map_ok = 1'b1;
		if (in_tbl)
			rd_d = {16'h0000, ra_data};
		else if (paddr == `PSAS_CTRL)
			rd_d = {28'h0000000, smode_q, pmode_q};
		else if (paddr == `PSAS_VFSEL)
			rd_d = {28'h0000000, vf_q};
		else if (paddr == `PSAS_FMAX)
			rd_d = {16'h0000, fmax_q};
		else if (paddr == `PSAS_ACC1)
			rd_d = {16'h0000, acc1_q};
		else if (paddr == `PSAS_DEC1)
			rd_d = {16'h0000, dec1_q};
		else if (paddr == `PSAS_ACC2)
			rd_d = {16'h0000, acc2_q};
		else if (paddr == `PSAS_DEC2)
			rd_d = {16'h0000, dec2_q};
		else if (paddr == `PSAS_STATUS)
			rd_d = {24'h000000, nz_q == 8'h00, resume_q, st_q, step_q, seq_busy};
		else if (paddr == `PSAS_RAMPDUR)
			rd_d = {16'h0000, ramp_dur};
		else
			map_ok = 1'b0;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			pmode_q <= 1'b0;
			smode_q <= 3'd0;
			vf_q    <= 4'h0;
			fmax_q  <= `PSAS_RST_FMAX;
			acc1_q  <= `PSAS_RST_ACC;
			dec1_q  <= `PSAS_RST_ACC;
			acc2_q  <= `PSAS_RST_ACC;
			dec2_q  <= `PSAS_RST_ACC;
		end else begin
			pready  <= acc_ph & ~pready;
			pslverr <= acc_ph & ~pready & ~map_ok;
			// an unmapped access of either direction reads back zero
			if (acc_ph & ~pready & (~pwrite | ~map_ok))
				prdata <= rd_d;
			if (wr_go) begin
				if (paddr == `PSAS_CTRL) begin
					pmode_q <= pwdata[`PSAS_CTRL_PMODE];
					smode_q <= pwdata[`PSAS_CTRL_SMODE_HI:`PSAS_CTRL_SMODE_LO] > 3'd6 ?
					           3'd6 : pwdata[`PSAS_CTRL_SMODE_HI:`PSAS_CTRL_SMODE_LO];
				end else if (paddr == `PSAS_VFSEL)
					vf_q <= pwdata[3:0];
				else if (paddr == `PSAS_FMAX)
					fmax_q <= pwdata[15:0];
				else if (paddr == `PSAS_ACC1)
					acc1_q <= pwdata[15:0];
				else if (paddr == `PSAS_DEC1)
					dec1_q <= pwdata[15:0];
				else if (paddr == `PSAS_ACC2)
					acc2_q <= pwdata[15:0];
				else if (paddr == `PSAS_DEC2)
					dec2_q <= pwdata[15:0];
			end
		end
	end

	// round-robin fetch of the settings the control logic needs
	// a preset's ramps come before its speed, so a new target never uses stale times
	always @* begin
		case (ph_q)
		3'd0: rb_addr = `PSAS_IX_RAMP + {2'd0, sel_q, 1'b0};
		3'd1: rb_addr = `PSAS_IX_RAMP + {2'd0, sel_q, 1'b1};
		3'd2: rb_addr = {3'd0, sel_q};
		3'd3: rb_addr = step_q == 3'd0 ? 6'd0 : `PSAS_IX_SEQF + {3'd0, step_q};
		3'd4: rb_addr = `PSAS_IX_RTIME + {3'd0, step_q};
		3'd5: rb_addr = `PSAS_IX_DIR + {3'd0, step_q};
		default: rb_addr = `PSAS_IX_RTIME + {3'd0, rr_q};
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q    <= 3'd0;
			ph1_q   <= 3'd7;
			rr_q    <= 3'd0;
			rr1_q   <= 3'd0;
			sel_q   <= 3'd0;
			nz_q    <= 8'h00;
			spd_q   <= 16'h0000;
			sfrq_q  <= 16'h0000;
			stime_q <= 16'h0000;
			sdir_q  <= `PSAS_DIR_STOP;
			pacc_q  <= `PSAS_RST_ACC;
			pdec_q  <= `PSAS_RST_ACC;
		end else begin
			ph_q  <= ph_q == 3'd6 ? 3'd0 : ph_q + 3'd1;
			ph1_q <= ph_q;
			rr1_q <= rr_q;
			if (ph_q == 3'd6) begin
				rr_q  <= rr_q + 3'd1;
				sel_q <= speed_sel;
			end
			// cleared table entries must not give a zero ramp time
			case (ph1_q)
			3'd0: pacc_q  <= rb_data < `PSAS_RAMP_MIN ? `PSAS_RAMP_MIN : rb_data;
			3'd1: pdec_q  <= rb_data < `PSAS_RAMP_MIN ? `PSAS_RAMP_MIN : rb_data;
			3'd2: spd_q   <= rb_data;
			3'd3: sfrq_q  <= rb_data;
			3'd4: stime_q <= rb_data;
			3'd5: sdir_q  <= rb_data[1:0];
			3'd6: nz_q[rr1_q] <= rb_data != 16'h0000;
			default: nz_q <= nz_q;
			endcase
		end
	end

	always @* begin
		nfirst = nz_q[0] ? 4'h0 : nxt(3'd0, nz_q);
		nnext  = nxt(step_q, nz_q);
	end

	// sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= S_IDLE;
			step_q   <= 3'd0;
			elap_q   <= 16'h0000;
			tick_q   <= 32'h0000_0000;
			resume_q <= 1'b0;
			go_d1_q  <= 1'b0;
		end else begin
			go_d1_q <= seq_go;
			tick_q  <= (tick || st_q != S_RUN) ? 32'h0000_0000 : tick_q + 32'h0000_0001;
			case (st_q)
			S_IDLE: begin
				if (seq_go && !go_d1_q) begin
					if (!(resumable && resume_q)) begin
						step_q <= nfirst[2:0];
						elap_q <= 16'h0000;
					end
					resume_q <= 1'b0;
					st_q     <= nfirst[3] ? S_DONE : S_RUN;
				end
			end
			S_RUN: begin
				if (!seq_go) begin
					resume_q <= 1'b1;
					st_q     <= S_IDLE;
				end else if (tick) begin
					if (trun < stime_q) begin
						elap_q <= trun;
					end else begin
						elap_q <= 16'h0000;
						if (!nnext[3])
							step_q <= nnext[2:0];
						else if (smode_q == 3'd2 || smode_q == 3'd5)
							step_q <= nfirst[2:0];
						else if (smode_q == 3'd3 || smode_q == 3'd6)
							st_q <= S_HOLD;
						else
							st_q <= S_DONE;
					end
				end
			end
			default: begin
				// finished cycle: next run always begins fresh
				if (!seq_go) begin
					resume_q <= 1'b0;
					st_q     <= S_IDLE;
				end
			end
			endcase
		end
	end

	// command selection
	always @* begin
		if (seq_on) begin
			tgt     = sfrq_q;
			dir_now = sdir_q;
			run_now = sdir_q != `PSAS_DIR_STOP;
		end else if (seq_go || (smode_q != 3'd0 && seq_enable)) begin
			tgt     = freq_cmd;
			dir_now = `PSAS_DIR_STOP;
			run_now = 1'b0;
		end else begin
			tgt     = spd_q;
			dir_now = reverse_sel ? `PSAS_DIR_REV : `PSAS_DIR_FWD;
			run_now = run_switch;
		end
		if (!pmode_q || seq_on)
			rt_sel = tgt > freq_cmd ? (ramp_pair2_sel ? acc2_q : acc1_q) :
			         (ramp_pair2_sel ? dec2_q : dec1_q);
		else
			rt_sel = tgt > freq_cmd ? pacc_q : pdec_q;
		dlt = tgt > freq_cmd ? tgt - freq_cmd : freq_cmd - tgt;
		if (vf_q == `PSAS_VF_PROG)
			fmax_eff = fmax_q;
		else
			fmax_eff = vf_q < `PSAS_VF60_FIRST ? `PSAS_F50 : `PSAS_F60;
	end

	psas_div #(.NW(32), .DW(16)) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (tgt != freq_cmd),
		.num     (rt_sel * dlt),
		.den     (fmax_eff),
		.busy    (),
		.done    (div_done),
		.quo     (div_q)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_cmd   <= 16'h0000;
			run_cmd    <= 1'b0;
			fwd_cmd    <= 1'b0;
			rev_cmd    <= 1'b0;
			ramp_time  <= `PSAS_RST_ACC;
			ramp_accel <= 1'b0;
			ramp_dur   <= 16'h0000;
			seq_busy   <= 1'b0;
			seq_step   <= 3'd0;
		end else begin
			if (tgt != freq_cmd) begin
				ramp_time  <= rt_sel;
				ramp_accel <= tgt > freq_cmd;
			end
			freq_cmd <= tgt;
			run_cmd  <= run_now;
			fwd_cmd  <= run_now && dir_now == `PSAS_DIR_FWD;
			rev_cmd  <= run_now && dir_now == `PSAS_DIR_REV;
			seq_busy <= seq_on;
			seq_step <= step_q;
			// duration lags the new target by the divider's latency
			if (div_done)
				ramp_dur <= div_q;
		end
	end
endmodule

// [testbench/psas_checker.sv]
`timescale 1ns/1ps
`include "psas_consts.vh"
module psas_checker #(
	parameter TICK_CYC = 10
) (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [15:0] freq_cmd,
	input wire        run_cmd,
	input wire        fwd_cmd,
	input wire        rev_cmd,
	input wire [15:0] ramp_time,
	input wire        seq_busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
	property p_ready_wait;
		psel && $rose(penable) |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
	property p_ready_access;
		pready |-> psel && penable && $past(penable);
	endproperty
	a_ready_access: assert property (p_ready_access) else $error("pready outside access");
	property p_err_data;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("bad error response");
	property p_dir_onehot;
		run_cmd |-> fwd_cmd ^ rev_cmd;
	endproperty
	a_dir_onehot: assert property (p_dir_onehot) else $error("running without one direction");
	property p_stop_nodir;
		!run_cmd |-> !fwd_cmd && !rev_cmd;
	endproperty
	a_stop_nodir: assert property (p_stop_nodir) else $error("direction while stopped");
	property p_freq_range;
		freq_cmd <= `PSAS_FREQ_MAX;
	endproperty
	a_freq_range: assert property (p_freq_range) else $error("frequency above limit");
	property p_ramp_range;
		ramp_time >= `PSAS_RAMP_MIN && ramp_time <= `PSAS_TIME_MAX;
	endproperty
	a_ramp_range: assert property (p_ramp_range) else $error("ramp time out of range");
	c_err: cover property (pslverr);
	c_seq: cover property ($rose(seq_busy));
	c_rev: cover property (run_cmd && rev_cmd);
endmodule
bind psas_top psas_checker #(.TICK_CYC(TICK_CYC)) u_psas_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .freq_cmd(freq_cmd), .run_cmd(run_cmd),
	.fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd), .ramp_time(ramp_time), .seq_busy(seq_busy));

// [testbench/psas_term_model.sv]
`timescale 1ns/1ps
// run switch and multifunction terminals, changed only just after an edge
module psas_term_model (
	input  wire        pclk,
	output logic       run_switch,
	output logic       reverse_sel,
	output logic [2:0] speed_sel,
	output logic       ramp_pair2_sel,
	output logic       seq_enable
);
	initial begin
		run_switch = 1'b0;
		reverse_sel = 1'b0;
		speed_sel = 3'h0;
		ramp_pair2_sel = 1'b0;
		seq_enable = 1'b0;
	end
	task drive(input logic r, input logic v, input logic [2:0] s, input logic p, input logic q);
		@(posedge pclk);
		run_switch <= r;
		reverse_sel <= v;
		speed_sel <= s;
		ramp_pair2_sel <= p;
		seq_enable <= q;
	endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "psas_consts.vh"
module testbench;
	localparam TICK = 10;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rdat;
	logic        rerr;
	wire  [31:0] prdata;
	wire         pready, pslverr, run_switch, reverse_sel, ramp_pair2_sel, seq_enable;
	wire  [2:0]  speed_sel, seq_step;
	wire  [15:0] freq_cmd, ramp_time, ramp_dur;
	wire         run_cmd, fwd_cmd, rev_cmd, ramp_accel, seq_busy;
	int          bad_count = 0;
	int          compares = 0;
	int          cyc = 0;
	int          modes[6] = '{2, 5, 1, 4, 3, 6};
	int          m;
	int          kind;

	psas_top #(.TICK_CYC(TICK)) u_psas_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.run_switch(run_switch), .reverse_sel(reverse_sel), .speed_sel(speed_sel),
		.ramp_pair2_sel(ramp_pair2_sel), .seq_enable(seq_enable), .freq_cmd(freq_cmd),
		.run_cmd(run_cmd), .fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd), .ramp_time(ramp_time),
		.ramp_accel(ramp_accel), .ramp_dur(ramp_dur), .seq_busy(seq_busy), .seq_step(seq_step));
	psas_term_model u_term (
		.pclk(pclk), .run_switch(run_switch), .reverse_sel(reverse_sel), .speed_sel(speed_sel),
		.ramp_pair2_sel(ramp_pair2_sel), .seq_enable(seq_enable));

	always #10 pclk = ~pclk;

	// whole run is under 1500 cycles; this only cuts a hang
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	task final_report;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	function automatic logic [11:0] tbl(input logic [5:0] i);
		return `PSAS_TBL_BASE + {4'h0, i, 2'b00};
	endfunction

	task wait_step(input logic [2:0] s);
		while (seq_step !== s) @(posedge pclk);
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(`PSAS_CTRL, 32'h0);
		rdchk(`PSAS_FMAX, 32'h1770);
		rdchk(`PSAS_ACC1, 32'h64);
		apb(1'b0, tbl(6'h1f), 32'h0);
		chk({31'h0, rerr}, 32'h1);
		wr(tbl(6'h0), 32'hea60);
		rdchk(tbl(6'h0), {16'h0, `PSAS_FREQ_MAX});
		// back to standstill so the next change is an acceleration
		wr(tbl(6'h0), 32'h0);
		wr(tbl(6'h8), 32'h0);
		rdchk(tbl(6'h8), {16'h0, `PSAS_RAMP_MIN});
		// individual ramps, fixed 50 Hz ceiling
		wr(`PSAS_CTRL, 32'h1);
		wr(tbl(6'h1), 32'h3e8);
		wr(tbl(6'ha), 32'h32);
		u_term.drive(1'b1, 1'b0, 3'h1, 1'b0, 1'b0);
		repeat (60) @(posedge pclk);
		chk(32'(freq_cmd), 32'h3e8);
		chk(32'(ramp_time), 32'h32);
		chk({31'h0, ramp_accel}, 32'h1);
		chk(32'(ramp_dur), 32'ha);
		// shared pair 2, programmable ceiling
		wr(`PSAS_CTRL, 32'h0);
		wr(`PSAS_VFSEL, 32'h7);
		wr(`PSAS_FMAX, 32'hbb8);
		wr(`PSAS_ACC2, 32'h12c);
		wr(tbl(6'h3), 32'h9c4);
		u_term.drive(1'b1, 1'b1, 3'h3, 1'b1, 1'b0);
		repeat (60) @(posedge pclk);
		chk(32'(ramp_time), 32'h12c);
		chk(32'(ramp_dur), 32'h96);
		chk({31'h0, rev_cmd}, 32'h1);
		// three used steps, the rest left at zero time
		wr(tbl(6'h0), 32'h5dc);
		wr(tbl(6'h18), 32'hbb8);
		wr(tbl(6'h19), 32'h1388);
		wr(tbl(6'h20), 32'h4);
		wr(tbl(6'h21), 32'h5);
		wr(tbl(6'h22), 32'h3);
		wr(tbl(6'h28), 32'h1);
		wr(tbl(6'h29), 32'h1);
		wr(tbl(6'h2a), 32'h2);
		// periodic modes first so a later resume never starts at the final step
		for (int i = 0; i < 6; i++) begin
			m = modes[i];
			kind = m % 3;
			u_term.drive(1'b1, 1'b0, 3'h3, 1'b1, 1'b0);
			wr(`PSAS_CTRL, 32'(m << 1));
			u_term.drive(1'b1, 1'b0, 3'h3, 1'b1, 1'b1);
			repeat (15) @(posedge pclk);
			if (m > 3)
				chk(32'(freq_cmd), 32'h5dc);
			wait_step(3'h1);
			repeat (10) @(posedge pclk);
			chk(32'(freq_cmd), 32'hbb8);
			chk(32'(ramp_time), 32'h12c);
			chk({31'h0, fwd_cmd}, 32'h1);
			u_term.drive(1'b1, 1'b0, 3'h3, 1'b1, 1'b0);
			repeat (5) @(posedge pclk);
			u_term.drive(1'b1, 1'b0, 3'h3, 1'b1, 1'b1);
			repeat (10) @(posedge pclk);
			chk(32'(seq_step), (m < 4) ? 32'h1 : 32'h0);
			wait_step(3'h2);
			repeat (10) @(posedge pclk);
			chk(32'(freq_cmd), 32'h1388);
			chk({31'h0, rev_cmd}, 32'h1);
			repeat (60) @(posedge pclk);
			chk({31'h0, seq_busy}, {31'h0, kind != 1});
			chk({31'h0, run_cmd}, {31'h0, kind != 1});
			chk({31'h0, seq_step == 3'h2}, {31'h0, kind != 2});
		end
		wr(`PSAS_CTRL, 32'h0);
		repeat (12) @(posedge pclk);
		chk({31'h0, seq_busy}, 32'h0);
		chk(32'(freq_cmd), 32'h9c4);
		final_report();
	end
endmodule
